// file: verilog/flash_prot_pkg.sv
package flash_prot_pkg;

  // Instruction codes seen by this block.
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_SR1     = 8'h01;
  localparam logic [7:0] OP_WRITE_SR2     = 8'h31;
  localparam logic [7:0] OP_SUSPEND       = 8'h75;
  localparam logic [7:0] OP_RESUME        = 8'h7a;

  // Status word bit positions.
  localparam int BUSY_BIT  = 0;
  localparam int WPL_BIT   = 1;
  localparam int SIZE_LO   = 2;
  localparam int SIZE_HI   = 4;
  localparam int LOW_BIT   = 5;
  localparam int GRAN_BIT  = 6;
  localparam int LOCK_LO   = 7;
  localparam int LOCK_HI   = 8;
  localparam int QUAD_BIT  = 9;
  localparam int INV_BIT   = 14;
  localparam int PAUSE_BIT = 15;

  // Bits that a status write may change; the same bits are non-volatile.
  localparam logic [15:0] NV_MASK  = 16'h43fc;
  localparam logic [15:0] SR_RESET = 16'h0000;

  // Lock-mode encodings, high bit first.
  localparam logic [1:0] LOCK_SOFT = 2'h0;
  localparam logic [1:0] LOCK_HW   = 2'h1;
  localparam logic [1:0] LOCK_PWR  = 2'h2;
  localparam logic [1:0] LOCK_OTP  = 2'h3;

  // Size codes and region sizes in bytes.
  localparam logic [2:0]  SIZE_NONE   = 3'h0;
  localparam logic [2:0]  SIZE_ALL    = 3'h7;
  localparam logic [24:0] ARRAY_BYTES = 25'h1000000;
  localparam logic [24:0] BLK_UNIT    = 25'h0040000;
  localparam logic [24:0] SEC_UNIT    = 25'h0001000;
  localparam logic [24:0] SEC_MAX     = 25'h0008000;
  localparam logic [23:0] FIRST_ADDR  = 24'h000000;
  localparam logic [23:0] LAST_ADDR   = 24'hffffff;

  // Width of the write-cycle counter.
  localparam int CNT_W = 16;

  // Whole state of the protection block.
  typedef struct packed {
    logic [15:0]      sr;
    logic [CNT_W-1:0] busy_cnt;
    logic             loaded;
    logic             guard_meta;
    logic             guard_sync;
    logic             wr_ok;
    logic             wr_ref;
    logic             pe_ok;
    logic             pe_no;
    logic             p_none;
    logic [23:0]      p_lo;
    logic [23:0]      p_hi;
  } prot_state_s;

endpackage

// file: verilog/flash_status_write_protect.sv
// How it works
// - Two lock-mode bits choose status write protection.
// - Mode 00 accepts writes once permit latch set.
// - Mode 01 with guard pin low refuses.
// - Mode 01 with guard high needs permit latch.
// - Mode 10 refuses writes until power cycle.
// - Power cycle turns lock mode 10 into 00.
// - Mode 11 locks status writes for ever.
// - Four-lane bit turns guard pins into data.
// - Invert bit complements the selected protected range.
// - Suspend instruction sets the paused flag.
// - Resume or power cycle clears paused flag.
// - Block grain, top: upper 1/64 up to 1/2.
// - Block grain, bottom: lower 1/64 up to 1/2.
// - Size 000 protects nothing, 111 protects all.
// - Sector grain, top: 4KB to 32KB at end.
// - Sector grain, bottom: 4KB to 32KB at start.
// - Inverted top block size 001 leaves only top 256KB.
// - Program or erase touching protection is ignored.
// - Permit latch set by enable, cleared by accepted writes.
// - Size, low-end and granularity bits in status.
`timescale 1ns/1ns
`default_nettype none

module flash_status_write_protect
  import flash_prot_pkg::*;
#(
  parameter logic [CNT_W-1:0] WRITE_CYCLES = 16'h0010
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] nv_image,
  input  wire logic        write_guard_n,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] sr_wdata,
  input  wire logic        sr_two_bytes,
  input  wire logic        pe_valid,
  input  wire logic [23:0] pe_start,
  input  wire logic [23:0] pe_end,
  output logic [15:0]      status_word,
  output logic [15:0]      nv_store,
  output logic             busy,
  output logic             ready,
  output logic             four_lane_enable,
  output logic             guard_pins_active,
  output logic             sr_wr_accepted,
  output logic             sr_wr_refused,
  output logic             pe_grant,
  output logic             pe_deny,
  output logic             prot_none,
  output logic [23:0]      prot_lo,
  output logic [23:0]      prot_hi
);

  // Decodes the protected range as {none, low address, high address}.
  function automatic logic [48:0] prot_range(input logic [15:0] s);
    logic [2:0]  code;
    logic [24:0] size;
    logic        all_b;
    logic        none_b;
    logic [23:0] lo;
    logic [23:0] hi;
    logic [23:0] r_lo;
    logic [23:0] r_hi;
    logic        r_none;
    code   = s[SIZE_HI:SIZE_LO];
    all_b  = (code == SIZE_ALL);
    none_b = (code == SIZE_NONE);
    if (s[GRAN_BIT]) begin
      size = code[2] ? SEC_MAX : (SEC_UNIT << (code - 3'h1));
    end else begin
      size = BLK_UNIT << (code - 3'h1);
    end
    // bottom block regions start at zero.
    if (s[LOW_BIT]) begin
      lo = FIRST_ADDR;
      hi = 24'(size - 25'h1);
    end else begin
      // top regions end at the last address.
      lo = 24'(ARRAY_BYTES - size);
      hi = LAST_ADDR;
    end
    // all and none ignore grain and end.
    if (all_b) begin
      lo = FIRST_ADDR;
      hi = LAST_ADDR;
    end
    r_none = none_b;
    r_lo   = lo;
    r_hi   = hi;
    // invert swaps protected and free parts.
    if (s[INV_BIT]) begin
      r_none = all_b;
      if (none_b) begin
        r_lo = FIRST_ADDR;
        r_hi = LAST_ADDR;
      end else if (!s[LOW_BIT]) begin
        // inverted top leaves the top writable.
        r_lo = FIRST_ADDR;
        r_hi = lo - 24'h1;
      end else begin
        r_lo = hi + 24'h1;
        r_hi = LAST_ADDR;
      end
    end
    return {r_none, r_lo, r_hi};
  endfunction

  prot_state_s st;       // Registered state.
  prot_state_s next_st;  // Value for the next edge.

  logic [1:0]  lock_mode;    // High and low lock-mode bits.
  logic        guard_high;   // Guard pin seen as high, or not in use.
  logic        lock_allows;  // Lock mode lets a permitted write through.
  logic        idle;         // Loaded and not in a write cycle.
  logic        sr_write_req; // A status write instruction is presented.
  logic        overlap;      // Program or erase target hits protection.
  logic [15:0] wr_value;     // Status word proposed by the write.

  // the lock mode is read from its two status bits.
  assign lock_mode = {st.sr[LOCK_HI], st.sr[LOCK_LO]};
  assign busy      = (st.busy_cnt != '0);
  assign idle      = st.loaded && !busy;
  assign ready     = idle;

  // with four lanes on, the guard pin is a data line and stops guarding.
  assign four_lane_enable  = st.sr[QUAD_BIT];
  assign guard_pins_active = !st.sr[QUAD_BIT];
  assign guard_high        = st.sr[QUAD_BIT] || st.guard_sync;

  assign sr_write_req = idle && cmd_valid &&
                        (cmd_code == OP_WRITE_SR1 || cmd_code == OP_WRITE_SR2);

  // Lock-mode decision; the permit latch is checked separately.
  always_comb begin
    case (lock_mode)
      // software mode ignores the guard pin.
      LOCK_SOFT: lock_allows = 1'b1;
      // hardware mode with the pin low refuses.
      // hardware mode with the pin high needs the latch.
      LOCK_HW:   lock_allows = guard_high;
      // power-supply lock refuses until the next power cycle.
      LOCK_PWR:  lock_allows = 1'b0;
      LOCK_OTP:  lock_allows = 1'b0;
      default:   lock_allows = 1'b0;
    endcase
  end

  // Merge the written bytes; a one-byte first-register write keeps the upper byte.
  always_comb begin
    wr_value = st.sr;
    if (cmd_code == OP_WRITE_SR2) begin
      wr_value[15:8] = sr_wdata[15:8];
    end else begin
      wr_value[7:0] = sr_wdata[7:0];
      if (sr_two_bytes) begin
        wr_value[15:8] = sr_wdata[15:8];
      end
    end
  end

  // any protected byte in the target range blocks the whole request.
  assign overlap = !st.p_none && (pe_start <= st.p_hi) && (pe_end >= st.p_lo);

  // Next-state logic for the whole block.
  always_comb begin
    logic [48:0] rng;
    rng     = prot_range(st.sr);
    next_st = st;
    next_st.guard_meta = write_guard_n;
    next_st.guard_sync = st.guard_meta;
    next_st.wr_ok      = 1'b0;
    next_st.wr_ref     = 1'b0;
    next_st.pe_ok      = 1'b0;
    next_st.pe_no      = 1'b0;
    next_st.p_none     = rng[48];
    next_st.p_lo       = rng[47:24];
    next_st.p_hi       = rng[23:0];
    if (!st.loaded) begin
      // The stored image is taken once, on the first edge after power-up.
      next_st.loaded = 1'b1;
      // size, end and grain bits come back from the stored image.
      next_st.sr = nv_image & NV_MASK;
      // a power-supply lock does not survive the power cycle.
      if ({nv_image[LOCK_HI], nv_image[LOCK_LO]} == LOCK_PWR) begin
        next_st.sr[LOCK_HI] = 1'b0;
        next_st.sr[LOCK_LO] = 1'b0;
      end
    end else begin
      if (busy) begin
        next_st.busy_cnt = st.busy_cnt - 1'b1;
      end
      if (sr_write_req) begin
        if (lock_allows && st.sr[WPL_BIT]) begin
          next_st.sr    = (st.sr & ~NV_MASK) | (wr_value & NV_MASK);
          // an accepted status write drops the permit latch.
          next_st.sr[WPL_BIT] = 1'b0;
          next_st.busy_cnt    = WRITE_CYCLES;
          next_st.wr_ok       = 1'b1;
        end else begin
          // a refused write leaves the word alone and starts no cycle.
          next_st.wr_ref = 1'b1;
        end
      end
      if (idle && pe_valid) begin
        // grant only with the latch set and no protected byte hit.
        next_st.pe_ok = st.sr[WPL_BIT] && !overlap;
        next_st.pe_no = !(st.sr[WPL_BIT] && !overlap);
        // program and erase drop the permit latch.
        next_st.sr[WPL_BIT] = 1'b0;
      end
      if (idle && cmd_valid) begin
        case (cmd_code)
          // write enable sets the latch and wins over a clear.
          OP_WRITE_ENABLE:  next_st.sr[WPL_BIT] = 1'b1;
          OP_WRITE_DISABLE: next_st.sr[WPL_BIT] = 1'b0;
          default:          next_st.sr[WPL_BIT] = next_st.sr[WPL_BIT];
        endcase
      end
      // Suspend and resume are heard even while a write cycle runs.
      if (cmd_valid && cmd_code == OP_SUSPEND) begin
        next_st.sr[PAUSE_BIT] = 1'b1;
      end else if (cmd_valid && cmd_code == OP_RESUME) begin
        next_st.sr[PAUSE_BIT] = 1'b0;
      end
    end
  end

  // State register; reset stands for power-up and clears the paused flag.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st <= '{sr: SR_RESET, busy_cnt: '0, p_lo: FIRST_ADDR, p_hi: FIRST_ADDR,
              p_none: 1'b1, guard_meta: 1'b1, guard_sync: 1'b1, default: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs; the busy bit is shown in the word's lowest position.
  assign status_word    = {st.sr[15:1], busy};
  assign nv_store       = st.sr & NV_MASK;
  assign sr_wr_accepted = st.wr_ok;
  assign sr_wr_refused  = st.wr_ref;
  assign pe_grant       = st.pe_ok;
  assign pe_deny        = st.pe_no;
  assign prot_none      = st.p_none;
  assign prot_lo        = st.p_lo;
  assign prot_hi        = st.p_hi;

  // Checks on the lock modes, range decode and flags.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_otp_refuse: assert property (
    sr_write_req && lock_mode == LOCK_OTP |=> sr_wr_refused && $stable(nv_store))
    else $error("write taken under permanent lock");

  chk_pwr_refuse: assert property (
    sr_write_req && lock_mode == LOCK_PWR |=> sr_wr_refused && !busy)
    else $error("write taken under power lock");

  chk_hw_pin_low: assert property (
    sr_write_req && lock_mode == LOCK_HW && !guard_high |=> sr_wr_refused)
    else $error("write taken with guard pin low");

  chk_hw_pin_high: assert property (
    sr_write_req && lock_mode == LOCK_HW && guard_high && st.sr[WPL_BIT]
    |=> sr_wr_accepted ##1 busy)
    else $error("write refused with guard pin high");

  chk_soft_accept: assert property (
    sr_write_req && lock_mode == LOCK_SOFT && st.sr[WPL_BIT]
    |=> sr_wr_accepted && !status_word[WPL_BIT] ##0 busy[*8])
    else $error("software-mode write not carried out");

  chk_refuse_quiet: assert property (
    sr_wr_refused |-> !busy && status_word == $past(status_word))
    else $error("refused write changed status");

  chk_pause_set: assert property (
    st.loaded && cmd_valid && cmd_code == OP_SUSPEND |=> status_word[PAUSE_BIT])
    else $error("suspend did not set paused flag");

  chk_pause_clear: assert property (
    st.loaded && cmd_valid && cmd_code == OP_RESUME |=> !status_word[PAUSE_BIT])
    else $error("resume did not clear paused flag");

  chk_top_64th: assert property (
    !st.sr[INV_BIT] && st.sr[GRAN_BIT:SIZE_LO] == 5'h01
    |=> prot_lo == 24'hfc0000 && prot_hi == LAST_ADDR && !prot_none)
    else $error("upper 1/64 range wrong");

  chk_inv_top: assert property (
    st.sr[INV_BIT] && st.sr[GRAN_BIT:SIZE_LO] == 5'h01
    |=> prot_lo == FIRST_ADDR && prot_hi == 24'hfbffff)
    else $error("inverted 1/64 range wrong");

  chk_pe_blocked: assert property (
    idle && pe_valid && overlap |=> pe_deny && !pe_grant ##1 !busy)
    else $error("protected program or erase granted");

  chk_latch_set: assert property (
    idle && cmd_valid && cmd_code == OP_WRITE_ENABLE |=> status_word[WPL_BIT])
    else $error("write enable did not set latch");

  chk_latch_drop: assert property (
    idle && (pe_valid || (cmd_valid && cmd_code == OP_WRITE_DISABLE)) &&
    !(cmd_valid && cmd_code == OP_WRITE_ENABLE) |=> !status_word[WPL_BIT])
    else $error("permit latch not cleared");

  chk_lane_guard: assert property (
    sr_write_req && lock_mode == LOCK_HW && four_lane_enable && st.sr[WPL_BIT]
    |=> sr_wr_accepted)
    else $error("guard pin still guarding in four-lane mode");

  chk_bottom_64th: assert property (
    !st.sr[INV_BIT] && st.sr[GRAN_BIT:SIZE_LO] == 5'h09
    |=> prot_lo == FIRST_ADDR && prot_hi == 24'h03ffff && !prot_none)
    else $error("lower 1/64 range wrong");

  chk_sector_low: assert property (
    !st.sr[INV_BIT] && st.sr[GRAN_BIT:SIZE_LO] == 5'h19
    |=> prot_lo == FIRST_ADDR && prot_hi == 24'h000fff && !prot_none)
    else $error("bottom 4KB range wrong");

  // The load edge is the only place where a power lock may be dropped.
  chk_pwr_release: assert property (
    $rose(st.loaded) |-> lock_mode != LOCK_PWR)
    else $error("power lock survived power cycle");

  cov_soft_write: cover property (sr_write_req && lock_mode == LOCK_SOFT ##1 sr_wr_accepted);
  cov_hw_refuse:  cover property (sr_write_req && lock_mode == LOCK_HW ##1 sr_wr_refused);
  cov_pe_deny:    cover property (pe_valid ##1 pe_deny);
  cov_pe_grant:   cover property (pe_valid ##1 pe_grant);
  cov_pause:      cover property (status_word[PAUSE_BIT] ##[1:20] !status_word[PAUSE_BIT]);

endmodule

`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Host controller model: hands the block one decoded instruction at a time.
module host_model
  import flash_prot_pkg::*;
#(
  parameter bit PINS_TIED = 1'b0
) (
  input  wire logic        sys_clk,
  output logic             cmd_valid,
  output logic [7:0]       cmd_code,
  output logic [15:0]      sr_wdata,
  output logic             sr_two_bytes,
  output logic             pe_valid,
  output logic [23:0]      pe_start,
  output logic [23:0]      pe_end
);
  // Idle cycles put in front of each instruction, so the host can also be slow.
  int gap = 0;

  // Every output is defined from time zero.
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'hff;
    sr_wdata = 16'h0000;
    sr_two_bytes = 1'b0;
    pe_valid = 1'b0;
    pe_start = 24'h000000;
    pe_end = 24'h000000;
  end

  // One instruction pulse; afterwards the data is inverted so that no stale value helps.
  task automatic send(input logic [7:0] code, input logic [15:0] data);
    repeat (gap) @(negedge sys_clk);
    if (PINS_TIED && code == OP_WRITE_SR1) begin
      data[QUAD_BIT] = 1'b0;
    end
    @(negedge sys_clk);
    cmd_code = code;
    sr_wdata = data;
    sr_two_bytes = 1'b1;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_code = 8'hff;
    sr_wdata = ~data;
  endtask

  // One program or erase request over an inclusive byte range.
  task automatic pe_request(input logic [23:0] lo, input logic [23:0] hi);
    @(negedge sys_clk);
    pe_start = lo;
    pe_end = hi;
    pe_valid = 1'b1;
    @(negedge sys_clk);
    pe_valid = 1'b0;
    pe_start = ~lo;
    pe_end = ~hi;
  endtask
endmodule

`default_nettype wire

// file: tb/tb_flash_status_write_protect.sv
`timescale 1ns/1ns
`default_nettype none

module tb_flash_status_write_protect;
  import flash_prot_pkg::*;

  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] nv_image = 16'h0000;
  logic        write_guard_n = 1'b1;
  logic        cmd_valid, sr_two_bytes, pe_valid;
  logic [7:0]  cmd_code;
  logic [15:0] sr_wdata, status_word, nv_store;
  logic [23:0] pe_start, pe_end, prot_lo, prot_hi;
  logic        busy, ready, four_lane_enable, guard_pins_active;
  logic        sr_wr_accepted, sr_wr_refused, pe_grant, pe_deny, prot_none;
  int          fails = 0;
  int          total_checks = 0;
  // Range table: status value, then expected low and high; low above high means none.
  logic [15:0] rs [12] = '{16'h0004, 16'h0018, 16'h0024, 16'h0038, 16'h0000, 16'h007c,
                           16'h0044, 16'h0054, 16'h0064, 16'h0070, 16'h4004, 16'h401c};
  logic [47:0] rr [12] = '{48'hfc0000ffffff, 48'h800000ffffff, 48'h00000003ffff,
                           48'h0000007fffff, 48'hffffff000000, 48'h000000ffffff,
                           48'hfff000ffffff, 48'hff8000ffffff, 48'h000000000fff,
                           48'h000000007fff, 48'h000000fbffff, 48'hffffff000000};

  // Free-running 100 MHz clock.
  always #5 sys_clk = ~sys_clk;

  host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .sr_wdata(sr_wdata), .sr_two_bytes(sr_two_bytes), .pe_valid(pe_valid),
    .pe_start(pe_start), .pe_end(pe_end));

  // A short write cycle keeps the run brief; eight or more keeps the busy check valid.
  flash_status_write_protect #(.WRITE_CYCLES(16'h000a)) uut (.sys_clk(sys_clk),
    .rstn(rstn), .nv_image(nv_image), .write_guard_n(write_guard_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .sr_wdata(sr_wdata),
    .sr_two_bytes(sr_two_bytes), .pe_valid(pe_valid), .pe_start(pe_start),
    .pe_end(pe_end), .status_word(status_word), .nv_store(nv_store), .busy(busy),
    .ready(ready), .four_lane_enable(four_lane_enable),
    .guard_pins_active(guard_pins_active), .sr_wr_accepted(sr_wr_accepted),
    .sr_wr_refused(sr_wr_refused), .pe_grant(pe_grant), .pe_deny(pe_deny),
    .prot_none(prot_none), .prot_lo(prot_lo), .prot_hi(prot_hi));

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compares any value of up to 24 bits; case inequality lets no unknown through.
  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait for the write cycle to end.
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 100) begin
      fails++;
      $display("ERROR %0t ready never returned", $time);
      test_done();
    end
  endtask

  // A power cycle: reset for four cycles, then the stored image is loaded.
  task automatic power(input logic [15:0] img);
    @(negedge sys_clk);
    rstn = 1'b0;
    nv_image = img;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask

  // Enable then status write; a refusal must leave busy low.
  task automatic sr_write(input logic [15:0] d, input logic ok);
    host.send(OP_WRITE_ENABLE, 16'h0000);
    host.send(OP_WRITE_SR1, d);
    check(sr_wr_accepted, ok, "accepted");
    check(sr_wr_refused, !ok, "refused");
    check(busy, ok, "busy");
    wait_ready();
  endtask

  // Guard pin change, given time to pass the two-stage synchroniser.
  task automatic guard(input logic lvl);
    write_guard_n = lvl;
    repeat (3) @(negedge sys_clk);
  endtask

  initial begin
    power(16'h0104);
    check(status_word, 16'h0004, "lock 10 after power");
    for (int i = 0; i < 12; i++) begin
      sr_write(rs[i], 1'b1);
      check(status_word, rs[i], "status");
      check(nv_store, rs[i], "stored");
      check(prot_none, rr[i][47:24] > rr[i][23:0], "none");
      // Bounds only matter where something is protected.
      if (rr[i][47:24] <= rr[i][23:0]) begin
        check(prot_lo, rr[i][47:24], "low end");
        check(prot_hi, rr[i][23:0], "high end");
      end
    end
    // Program and erase against the top 256KB block.
    sr_write(16'h0004, 1'b1);
    host.send(OP_WRITE_ENABLE, 16'h0000);
    host.pe_request(24'hfbf000, 24'hfbffff);
    check(pe_grant, 1'b1, "grant below");
    host.send(OP_WRITE_ENABLE, 16'h0000);
    host.pe_request(24'hfbf000, 24'hfc0000);
    check(pe_deny, 1'b1, "deny overlap");
    host.pe_request(24'h000000, 24'h000000);
    check(pe_deny, 1'b1, "deny no latch");
    host.send(OP_WRITE_ENABLE, 16'h0000);
    check(status_word[WPL_BIT], 1'b1, "latch set");
    host.send(OP_WRITE_DISABLE, 16'h0000);
    check(status_word[WPL_BIT], 1'b0, "latch clear");
    // Hardware mode with the guard pin in both states.
    sr_write(16'h0080, 1'b1);
    guard(1'b0);
    sr_write(16'h0084, 1'b0);
    // The refused write leaves the permit latch from its enable standing.
    check(status_word, 16'h0082, "unchanged");
    guard(1'b1);
    sr_write(16'h0084, 1'b1);
    host.send(OP_WRITE_SR1, 16'h0088);
    check(sr_wr_refused, 1'b1, "no enable");
    // Four-lane mode takes the guard pin away from protection.
    sr_write(16'h0280, 1'b1);
    check(four_lane_enable, 1'b1, "four lane");
    check(guard_pins_active, 1'b0, "pins data");
    guard(1'b0);
    sr_write(16'h0000, 1'b1);
    sr_write(16'h0004, 1'b1);
    guard(1'b1);
    // Supply lock-down and one-time lock.
    sr_write(16'h0100, 1'b1);
    sr_write(16'h0104, 1'b0);
    power(nv_store);
    check(status_word, 16'h0000, "lock-down released");
    sr_write(16'h0180, 1'b1);
    sr_write(16'h0000, 1'b0);
    power(16'h0180);
    sr_write(16'h0000, 1'b0);
    // Suspend and resume, with a slow host.
    host.gap = 2;
    host.send(OP_SUSPEND, 16'h0000);
    check(status_word[PAUSE_BIT], 1'b1, "paused");
    host.send(OP_RESUME, 16'h0000);
    check(status_word[PAUSE_BIT], 1'b0, "resumed");
    host.send(OP_SUSPEND, 16'h0000);
    power(16'h0180);
    check(status_word, 16'h0180, "paused cleared");
    test_done();
  end
endmodule

`default_nettype wire
